//--- core/lct_regs.vh
/*
 * register map, field masks, reset values and error codes of the
 * channel tuning control block.
 * assumes: included by every file of the block by its bare name.
 */
`ifndef LCT_REGS_VH
`define LCT_REGS_VH

// ==========================================================
// register indices (byte address = 4 * index)
// ==========================================================
`define LCT_IDX_OPSTAT 6'h00
`define LCT_IDX_FSTAT 6'h20
`define LCT_IDX_FTRIG 6'h29
`define LCT_IDX_CHAN 6'h30
`define LCT_IDX_RESET_ENABLE_REG 6'h32
`define LCT_IDX_MCFG 6'h33
`define LCT_IDX_GRID 6'h34
`define LCT_IDX_FCF1 6'h35
`define LCT_IDX_FCF2 6'h36
`define LCT_IDX_DEFCH 6'h3E

// ==========================================================
// field masks
// ==========================================================
`define LCT_MCFG_SDF 16'h0002
`define LCT_RESET_ENABLE_REG_SW_OUTPUT_ENABLE 16'h0008
`define LCT_RESET_ENABLE_REG_RESTORE 16'h0001
`define LCT_FSTAT_DIS 16'h1000
`define LCT_OPSTAT_PEND 16'h0100
`define LCT_DEFCH_SAVE 16'h0001

// ==========================================================
// reset values and limits
// ==========================================================
`define LCT_RST_CHAN 16'h0001
`define LCT_RST_FTRIG 16'h000F
`define LCT_RST_GRID 16'h0032
`define LCT_RST_FCF1 16'h00C4
`define LCT_RST_FCF2 16'h0000
`define LCT_CHAN_MAX 16'h00C8

// ==========================================================
// error field codes
// ==========================================================
`define LCT_ERR_OK 4'h0
`define LCT_ERR_RVE 4'h4
`define LCT_ERR_EXF 4'h8

// ==========================================================
// frequency scaling: first channel THz part in 0.1 GHz units
// ==========================================================
`define LCT_THZ_TENTHS 32'h0000_2710

`endif

//--- core/lct_freq_calc.v
/*
 * target frequency of a channel, in units of 0.1 GHz.
 * assumes: inputs hold steady while a tune is requested; the result
 * is registered and lags the inputs by one clock.
 */
`timescale 1ns/10ps
`include "lct_regs.vh"

module lct_freq_calc (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // channel map
    input wire [15:0] chan,
    input wire [15:0] grid,
    input wire [15:0] fcf_thz,
    input wire [15:0] fcf_ghz10,
    // result
    output reg [31:0] freq_q
);

    // ==========================================================
    // arithmetic
    // ==========================================================
    // grid is tenths of GHz, so keeping tenths avoids a divider
    wire signed [16:0] step_cnt = $signed({1'b0, chan}) - 17'sh0_0001;
    // signed grid sets the direction of increasing channel
    wire signed [33:0] offs = step_cnt * $signed(grid);
    wire [31:0] base = fcf_thz * `LCT_THZ_TENTHS + {16'h0000, fcf_ghz10};
    wire [31:0] freq_d = base + offs[31:0];

    // result register
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            freq_q <= 32'h0000_0000;
        end else begin
            freq_q <= freq_d;
        end
    end

endmodule

//--- core/lct_top.v
/*
 * channel select register bank with tuning sequencer and optical
 * output gating, reached as an ahb-lite slave.
 * assumes: one ahb-lite master, word transfers only; the tuning
 * hardware answers each tune_start with tune_done or tune_fail.
 */
`timescale 1ns/10ps
`include "lct_regs.vh"

module lct_top (
    // ahb-lite slave
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    // device pins
    input wire hw_output_disable_pin,
    input wire [15:0] fatal_events,
    // tuning hardware
    input wire tune_done,
    input wire tune_fail,
    output reg tune_start,
    output reg [15:0] tune_chan,
    output wire [31:0] tune_freq,
    output reg optical_out_en
);

    // ==========================================================
    // states
    // ==========================================================
    localparam ST_IDLE = 1'b0;
    localparam ST_TUNE = 1'b1;

    // ==========================================================
    // storage
    // ==========================================================
    reg [15:0] chan_q; // stored channel
    reg [15:0] def_chan_q; // saved default channel
    reg [15:0] fstat_q; // fatal status, sticky
    reg [15:0] ftrig_q; // fatal trigger mask
    reg [15:0] reset_enable_reg_q; // reset/enable, enable bit kept
    reg [15:0] mcfg_q; // module configuration
    reg [15:0] grid_q; // grid spacing, tenths of GHz
    reg [15:0] fcf1_q; // first channel, THz
    reg [15:0] fcf2_q; // first channel, tenths of GHz
    reg [3:0] err_q; // error field
    reg exf_q; // last tune failed
    reg state_q;
    reg [5:0] idx_q; // latched register index
    reg wr_q; // data phase is a write
    reg act_q; // data phase in progress

    // ==========================================================
    // field decode helpers
    // ==========================================================
    // a channel is valid only inside 1..max
    function chan_ok;
        input [15:0] c;
        begin
            chan_ok = (c != 16'h0000) && (c <= `LCT_CHAN_MAX);
        end
    endfunction

    function [15:0] opstat;
        input pend;
        input [3:0] err;
        begin
            opstat = (pend ? `LCT_OPSTAT_PEND : 16'h0000) | {12'h000, err};
        end
    endfunction

    // ==========================================================
    // bus decode
    // ==========================================================
    wire take = hsel && htrans[1] && hready;
    wire do_wr = act_q && wr_q;
    wire [15:0] wd = hwdata[15:0];
    wire wr_chan = do_wr && (idx_q == `LCT_IDX_CHAN);
    wire wr_reset_enable_reg = do_wr && (idx_q == `LCT_IDX_RESET_ENABLE_REG);
    wire wr_fstat = do_wr && (idx_q == `LCT_IDX_FSTAT);
    wire wr_defch = do_wr && (idx_q == `LCT_IDX_DEFCH);
    wire rd_opstat = act_q && !wr_q && (idx_q == `LCT_IDX_OPSTAT);

    // ==========================================================
    // enables and gating terms
    // ==========================================================
    wire sw_output_enable = |(reset_enable_reg_q & `LCT_RESET_ENABLE_REG_SW_OUTPUT_ENABLE);
    wire fatal_shutdown_enable = |(mcfg_q & `LCT_MCFG_SDF);
    wire sw_output_enable_set = wr_reset_enable_reg && |(wd & `LCT_RESET_ENABLE_REG_SW_OUTPUT_ENABLE);
    wire restore = wr_reset_enable_reg && |(wd & `LCT_RESET_ENABLE_REG_RESTORE);
    wire pin_en = hw_output_disable_pin; // high means hardware enabled
    wire chan_good = chan_ok(wd);
    // channel write is honoured only when valid
    wire chan_take = wr_chan && chan_good;
    // rising enable tunes; pin change alone does not
    wire go_sw_output_enable = sw_output_enable_set && !sw_output_enable && pin_en;
    wire go_chan = chan_take && (sw_output_enable || sw_output_enable_set) && pin_en;
    wire go = go_chan || go_sw_output_enable || (restore && sw_output_enable && pin_en);
    wire [15:0] go_ch = chan_take ? wd : (restore ? def_chan_q : chan_q);
    wire fatal = |(fstat_q & ftrig_q) && fatal_shutdown_enable;
    // output-disable equation
    // the live pin term darkens the output one cycle before the latched term would
    wire off_d = fatal || !sw_output_enable || !pin_en || |(fstat_q & `LCT_FSTAT_DIS);

    // ==========================================================
    // ahb-lite handshake: one wait state so read data is registered
    // ==========================================================
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            act_q <= 1'b0;
            wr_q <= 1'b0;
            idx_q <= 6'h00;
        end else begin
            hresp <= 1'b0; // always okay
            act_q <= take;
            hreadyout <= !take; // low for exactly one cycle
            if (take) begin
                idx_q <= haddr[7:2];
                wr_q <= hwrite;
            end
        end
    end

    // read mux; unmapped reads return zero
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (act_q && !wr_q) begin
            case (idx_q)
                `LCT_IDX_OPSTAT: hrdata <= {16'h0000, opstat(state_q, err_q)};
                `LCT_IDX_FSTAT: hrdata <= {16'h0000, fstat_q};
                `LCT_IDX_FTRIG: hrdata <= {16'h0000, ftrig_q};
                `LCT_IDX_CHAN: hrdata <= {16'h0000, chan_q};
                `LCT_IDX_RESET_ENABLE_REG: hrdata <= {16'h0000, reset_enable_reg_q};
                `LCT_IDX_MCFG: hrdata <= {16'h0000, mcfg_q};
                `LCT_IDX_GRID: hrdata <= {16'h0000, grid_q};
                `LCT_IDX_FCF1: hrdata <= {16'h0000, fcf1_q};
                `LCT_IDX_FCF2: hrdata <= {16'h0000, fcf2_q};
                `LCT_IDX_DEFCH: hrdata <= {16'h0000, def_chan_q};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // ==========================================================
    // configuration registers
    // ==========================================================
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ftrig_q <= `LCT_RST_FTRIG;
            reset_enable_reg_q <= 16'h0000;
            mcfg_q <= 16'h0000;
            grid_q <= `LCT_RST_GRID;
            fcf1_q <= `LCT_RST_FCF1;
            fcf2_q <= `LCT_RST_FCF2;
        end else if (do_wr) begin
            case (idx_q)
                `LCT_IDX_FTRIG: ftrig_q <= wd;
                // only the enable bit is held; restore is a strobe
                `LCT_IDX_RESET_ENABLE_REG: reset_enable_reg_q <= wd & `LCT_RESET_ENABLE_REG_SW_OUTPUT_ENABLE;
                `LCT_IDX_MCFG: mcfg_q <= wd;
                `LCT_IDX_GRID: grid_q <= wd;
                `LCT_IDX_FCF1: fcf1_q <= wd;
                `LCT_IDX_FCF2: fcf2_q <= wd;
                default: mcfg_q <= mcfg_q;
            endcase
        end
    end

    // ==========================================================
    // channel and saved default
    // ==========================================================
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chan_q <= `LCT_RST_CHAN;
            def_chan_q <= `LCT_RST_CHAN;
        end else begin
            if (chan_take) begin
                chan_q <= wd; // all 16 bits stored
            end else if (restore) begin
                chan_q <= def_chan_q;
            end
            // save writes the live channel as new default
            if (wr_defch && |(wd & `LCT_DEFCH_SAVE)) begin
                def_chan_q <= chan_q;
            end
        end
    end

    // ==========================================================
    // fatal status: events latch, write one clears, set wins
    // ==========================================================
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fstat_q <= 16'h0000;
        end else begin
            fstat_q <= (fstat_q & ~(wr_fstat ? wd : 16'h0000)
                       & ~(sw_output_enable_set ? `LCT_FSTAT_DIS : 16'h0000))
                       | (fatal_events & ~`LCT_FSTAT_DIS)
                       | (pin_en ? 16'h0000 : `LCT_FSTAT_DIS);
        end
    end

    // ==========================================================
    // tuning sequencer
    // ==========================================================
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= ST_IDLE;
            tune_start <= 1'b0;
            tune_chan <= `LCT_RST_CHAN;
            exf_q <= 1'b0;
        end else begin
            tune_start <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (go) begin
                        state_q <= ST_TUNE; // pending begins
                        tune_start <= 1'b1;
                        tune_chan <= go_ch;
                    end
                end
                ST_TUNE: begin
                    if (go) begin
                        // a new target supersedes the one in flight
                        tune_start <= 1'b1;
                        tune_chan <= go_ch;
                    end else if (tune_fail) begin
                        state_q <= ST_IDLE; // pending ends
                        exf_q <= 1'b1;
                    end else if (tune_done) begin
                        state_q <= ST_IDLE;
                        exf_q <= 1'b0;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // error field: read of op status clears, new error wins
    // ==========================================================
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            err_q <= `LCT_ERR_OK;
        end else if (wr_chan && !chan_good) begin
            err_q <= `LCT_ERR_RVE;
        end else if (state_q == ST_TUNE && !go && tune_fail) begin
            err_q <= `LCT_ERR_EXF;
        end else if (rd_opstat) begin
            err_q <= `LCT_ERR_OK;
        end
    end

    // ==========================================================
    // optical output gate
    // ==========================================================
    // the output stays dark while a tune is in flight or has failed
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            optical_out_en <= 1'b0;
        end else begin
            optical_out_en <= !off_d && !exf_q && (state_q == ST_IDLE);
        end
    end

    // ==========================================================
    // target frequency
    // ==========================================================
    lct_freq_calc u_freq (
        .hclk(hclk),
        .hresetn(hresetn),
        .chan(tune_chan),
        .grid(grid_q),
        .fcf_thz(fcf1_q),
        .fcf_ghz10(fcf2_q),
        .freq_q(tune_freq)
    );

endmodule

//--- tb/lct_tune_model.sv
/*
 * behavioural model of the tuning hardware behind the channel block.
 * assumes: each tune_start is answered after DLY+1 clocks by a one
 * clock done pulse, or a fail pulse while fail_mode is high.
 */
`timescale 1ns/10ps
module lct_tune_model #(parameter int DLY = 3) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // tuning handshake
    input wire logic tune_start,
    input wire logic fail_mode,
    output logic tune_done,
    output logic tune_fail
);
    logic [7:0] cnt_q; // clocks left before the answer
    logic busy_q; // a tune is under way
    // ==========================================================
    // tune sequencer: a new start restarts the count
    // ==========================================================
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_q <= 1'b0;
            cnt_q <= 8'h00;
            tune_done <= 1'b0;
            tune_fail <= 1'b0;
        end else begin
            tune_done <= 1'b0;
            tune_fail <= 1'b0;
            if (tune_start) begin
                busy_q <= 1'b1;
                cnt_q <= 8'(DLY);
            end else if (busy_q && cnt_q == 8'h00) begin
                busy_q <= 1'b0;
                tune_done <= !fail_mode;
                tune_fail <= fail_mode;
            end else if (busy_q) begin
                cnt_q <= cnt_q - 8'h01;
            end
        end
    end
endmodule

//--- tb/lct_top_asserts.sv
/*
 * concurrent checks on the ports of the channel tuning block.
 * assumes: bound to lct_top, one clock, async active low reset.
 */
`timescale 1ns/10ps
module lct_top_asserts (
    // bus side
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // device side
    input wire logic hw_output_disable_pin,
    input wire logic tune_done,
    input wire logic tune_fail,
    input wire logic tune_start,
    input wire logic [15:0] tune_chan,
    input wire logic optical_out_en
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic acc; // address phase taken this edge
    logic pend_q; // a tune is outstanding, one clock late
    assign acc = hsel && htrans[1] && hready;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_q <= 1'b0;
        end else if (tune_start) begin
            pend_q <= 1'b1;
        end else if (tune_done || tune_fail) begin
            pend_q <= 1'b0;
        end
    end
    sequence s_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    property p_wait; acc |=> s_wait; endproperty
    a_wait: assert property (p_wait) else $error("wait state wrong");
    property p_okay; !hresp; endproperty
    a_okay: assert property (p_okay) else $error("response not okay");
    property p_upper; hreadyout |-> hrdata[31:16] == 16'h0000; endproperty
    a_upper: assert property (p_upper) else $error("read data upper half set");
    property p_pulse; tune_start |=> !tune_start; endproperty
    a_pulse: assert property (p_pulse) else $error("start longer than one clock");
    property p_cause; tune_start |-> $past(acc && hwrite, 2); endproperty
    a_cause: assert property (p_cause) else $error("tune without write");
    property p_chan; $changed(tune_chan) |-> tune_start; endproperty
    a_chan: assert property (p_chan) else $error("channel moved without tune");
    property p_range; tune_start |-> tune_chan != 16'h0000 && tune_chan <= 16'h00C8; endproperty
    a_range: assert property (p_range) else $error("tune to invalid channel");
    property p_pin; !hw_output_disable_pin [*2] |-> !optical_out_en; endproperty
    a_pin: assert property (p_pin) else $error("output on with pin low");
    property p_pend; tune_start |=> !optical_out_en; endproperty
    a_pend: assert property (p_pend) else $error("output on while tuning");
    property p_fail; pend_q && tune_fail |=> !optical_out_en [*4]; endproperty
    a_fail: assert property (p_fail) else $error("output on after failed tune");
endmodule
bind lct_top lct_top_asserts u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .hw_output_disable_pin(hw_output_disable_pin),
    .tune_done(tune_done), .tune_fail(tune_fail), .tune_start(tune_start),
    .tune_chan(tune_chan), .optical_out_en(optical_out_en));

//--- tb/lct_top_tb.sv
/*
 * self-checking bench of the channel tuning block over ahb-lite.
 * assumes: lct_top with one wait state per transfer, tuning model.
 */
`timescale 1ns/10ps
`include "lct_regs.vh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
module lct_top_tb;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, pin = 0, fail_mode = 0;
    logic [31:0] haddr = 0, hwdata = 0, rv;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2;
    logic [15:0] fev = 0, bad[2] = '{16'h0000, 16'h00C9};
    wire [31:0] hrdata, tune_freq;
    wire [15:0] tune_chan;
    wire hreadyout, hresp, tune_start, tune_done, tune_fail, oen;
    int n_mismatch = 0, samples_checked = 0, n_start = 0, n;
    initial forever #12.5 hclk = ~hclk;
    always @(posedge hclk) if (tune_start === 1'b1) n_start++;
    initial begin #500000; n_mismatch++; final_report; end // hang guard
    lct_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .hw_output_disable_pin(pin),
        .fatal_events(fev), .tune_done(tune_done), .tune_fail(tune_fail),
        .tune_start(tune_start), .tune_chan(tune_chan), .tune_freq(tune_freq),
        .optical_out_en(oen));
    lct_tune_model #(.DLY(3)) u_tune (.hclk(hclk), .hresetn(hresetn),
        .tune_start(tune_start), .fail_mode(fail_mode), .tune_done(tune_done),
        .tune_fail(tune_fail));
    task automatic final_report;
        $display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // one single word transfer; address held until hready seen high
    task automatic xfer(input logic [5:0] idx, input logic w, input logic [15:0] d);
        int k = 0;
        @(posedge hclk);
        hsel <= 1'b1; htrans <= 2'b10; hwrite <= w; haddr <= {24'h0, idx, 2'b00};
        do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 20);
        hsel <= 1'b0; htrans <= 2'b00; hwdata <= {16'h0, d};
        do begin @(posedge hclk); k++; end while (hreadyout !== 1'b1 && k < 40);
        rv = hrdata;
        if (k >= 40) begin n_mismatch++; final_report; end
    endtask
    task automatic wr(input logic [5:0] idx, input logic [15:0] d); xfer(idx, 1'b1, d); endtask
    task automatic rd(input logic [5:0] idx); xfer(idx, 1'b0, 16'h0000); endtask
    // poll the pending bit, bounded
    task automatic wait_idle;
        int k;
        for (k = 0; k < 30; k++) begin
            rd(`LCT_IDX_OPSTAT);
            if (rv[8] === 1'b0) break;
        end
        if (k == 30) begin n_mismatch++; final_report; end
    endtask
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        // ==========================================================
        // reset values, unmapped read
        // ==========================================================
        rd(`LCT_IDX_CHAN); `CHK("chan", 32'h0000_0001, rv)
        rd(`LCT_IDX_GRID); `CHK("grid", 32'h0000_0032, rv)
        rd(`LCT_IDX_FCF1); `CHK("fcf1", 32'h0000_00C4, rv)
        rd(`LCT_IDX_FTRIG); `CHK("trig", 32'h0000_000F, rv)
        rd(6'h3F); `CHK("unmapped", 32'h0000_0000, rv)
        `CHK("freq", 32'(196 * 10000), tune_freq)
        `CHK("oen", 1'b0, oen)
        $display("test reset done");
        // enable after pin high starts a tune
        pin <= 1'b1;
        wr(`LCT_IDX_RESET_ENABLE_REG, 16'h0008); wait_idle;
        `CHK("oen", 1'b1, oen)
        // negative grid, top channel
        wr(`LCT_IDX_GRID, 16'hFE0C); wr(`LCT_IDX_FCF2, 16'h0BB8);
        wr(`LCT_IDX_CHAN, 16'h00C8); wait_idle;
        `CHK("tchan", 16'h00C8, tune_chan)
        `CHK("freq", 32'(196 * 10000 + 3000 - 199 * 500), tune_freq)
        n = n_start;
        rd(`LCT_IDX_CHAN); `CHK("chan", 32'h0000_00C8, rv)
        `CHK("starts", n, n_start)
        $display("test tune done");
        // rejected channels leave the register alone
        foreach (bad[i]) begin
            wr(`LCT_IDX_CHAN, bad[i]);
            rd(`LCT_IDX_OPSTAT); `CHK("err", 4'h4, rv[3:0])
            rd(`LCT_IDX_CHAN); `CHK("chan", 32'h0000_00C8, rv)
        end
        // failed tune then a good one
        fail_mode <= 1'b1;
        wr(`LCT_IDX_CHAN, 16'h0005); wait_idle;
        `CHK("err", 4'h8, rv[3:0])
        `CHK("oen", 1'b0, oen)
        fail_mode <= 1'b0;
        wr(`LCT_IDX_CHAN, 16'h0005); wait_idle;
        `CHK("oen", 1'b1, oen)
        $display("test errors done");
        // saved default channel comes back on restore
        wr(`LCT_IDX_DEFCH, 16'h0001);
        rd(`LCT_IDX_DEFCH); `CHK("defch", 32'h0000_0005, rv)
        wr(`LCT_IDX_CHAN, 16'h0007); wait_idle;
        wr(`LCT_IDX_RESET_ENABLE_REG, 16'h0009); wait_idle;
        rd(`LCT_IDX_CHAN); `CHK("chan", 32'h0000_0005, rv)
        `CHK("tchan", 16'h0005, tune_chan)
        $display("test default channel done");
        // fatal event with shutdown enabled
        wr(`LCT_IDX_MCFG, 16'h0002);
        fev <= 16'h0001;
        @(posedge hclk) fev <= 16'h0000;
        repeat (2) @(posedge hclk);
        `CHK("oen", 1'b0, oen)
        rd(`LCT_IDX_FSTAT); `CHK("fstat0", 1'b1, rv[0])
        wr(`LCT_IDX_FSTAT, 16'h0001);
        rd(`LCT_IDX_FSTAT); `CHK("fstat0", 1'b0, rv[0])
        // pin low latches, pin high alone does not tune
        pin <= 1'b0;
        repeat (3) @(posedge hclk);
        `CHK("oen", 1'b0, oen)
        rd(`LCT_IDX_FSTAT); `CHK("fstat12", 1'b1, rv[12])
        n = n_start;
        pin <= 1'b1;
        repeat (5) @(posedge hclk);
        `CHK("starts", n, n_start)
        wr(`LCT_IDX_RESET_ENABLE_REG, 16'h0000); wr(`LCT_IDX_RESET_ENABLE_REG, 16'h0008); wait_idle;
        rd(`LCT_IDX_FSTAT); `CHK("fstat12", 1'b0, rv[12])
        `CHK("oen", 1'b1, oen)
        $display("test output gating done");
        final_report;
    end
endmodule
